// *** dsb_pkg.sv ***
// Purpose: shared constants and types of the serial double-buffered code path
// Assumes: one 16-bit word per converter, pins sampled on ref_clk
// Notes:   no bus; all control and status bits are plain ports
package dsb_pkg;

    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned PIN_W       = 7;

    // frame length that makes a write valid; the counter saturates here
    localparam logic [CNT_W-1:0]  FRAME_BITS = 5'h10;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;

    // reset codes chosen by the reset-level select pin
    localparam logic [WORD_W-1:0] CODE_ZERO  = 16'h0000;
    localparam logic [WORD_W-1:0] CODE_MID   = 16'h8000;
    localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;

    localparam int unsigned MSB = WORD_W - 1;

    // positions of the pins in the synchroniser bundle
    localparam int unsigned PIN_CS    = 0;
    localparam int unsigned PIN_SCLK  = 1;
    localparam int unsigned PIN_DIN   = 2;
    localparam int unsigned PIN_LOAD  = 3;
    localparam int unsigned PIN_MODE  = 4;
    localparam int unsigned PIN_RLVL  = 5;
    localparam int unsigned PIN_SLEEP = 6;

    // gray-coded frame tracker
    typedef enum logic [1:0] {
        DSB_IDLE  = 2'b00,
        DSB_FRAME = 2'b01,
        DSB_CLOSE = 2'b11
    } dsb_state_t;

endpackage

// *** dsb_sync.sv ***
// Purpose: two-flop synchroniser for a bundle of asynchronous pins
// Assumes: each bit is an independent level, no bus coherence needed
// Notes:   not reset so that straps are tracked while the block is held
`timescale 1ns/1ps
module dsb_sync
    import dsb_pkg::*;
#(
    parameter int unsigned W = PIN_W
) (
    input  wire logic         ref_clk,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic [SYNC_STAGES-1:0] stage_r;
            logic [SYNC_STAGES-1:0] stage_nxt;
            always_comb begin
                stage_nxt = stage_r;
                if (clk_en) begin
                    stage_nxt = {stage_r[SYNC_STAGES-2:0], async_in[gi]};
                end
            end
            always_ff @(posedge ref_clk) begin
                stage_r <= stage_nxt;
            end
            assign sync_out[gi] = stage_r[SYNC_STAGES-1];
        end
    endgenerate

endmodule

// *** dsb_top.sv ***
// Purpose: serial write port and double-buffered code path of a converter
// Assumes: serial master clock well below ref_clk/4; pins are asynchronous
// Notes:   all pins but resetn and clk_en pass a two-flop synchroniser, so the block reacts a few
//          ref_clk cycles after each pin edge
//
// What this block does
// R1 - load input register only after valid frame
// R2 - output latch alone drives converter code
// R3 - strobe high holds latch, input register free
// R4 - strobe low makes latch follow input register
// R5 - strobe low: latch takes code at select rise
// R6 - strobe high blocks; later falling strobe loads
// R7 - word is sixteen bits under serial clock
// R8 - accept bits only while select low
// R9 - sample one bit per rising serial clock
// R10 - short frames discarded, registers keep values
// R11 - long frames keep the last sixteen bits
// R12 - shift register copied at select rising edge
// R13 - master releases select after sixteenth edge
// R14 - readback shifts old input word out
// R15 - readback past sixteen gives word then zeros
// R16 - master ignores readback of short frames
// R17 - chain mode pushes old bits out serially
// R18 - chain output changes on falling clock edges
// R19 - master sends sixteen clocks per chained device
// R20 - master raises select when chain transfer done
// R21 - master may pulse shared strobe for all
// R22 - reset sets registers to zero or midscale
// R23 - sleep keeps interface running and contents
// R24 - words travel most significant bit first
`timescale 1ns/1ps
module dsb_top
    import dsb_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    input  wire logic              cs_n,
    input  wire logic              sclk,
    input  wire logic              din,
    input  wire logic              latch_load_strobe_n,
    input  wire logic              readback_or_chain_select,
    input  wire logic              reset_level_select,
    input  wire logic              sleep_pin,
    output logic                   sdo,
    output logic      [WORD_W-1:0] dac_code,
    output logic      [WORD_W-1:0] input_word,
    output logic                   powered_down,
    output logic                   frame_busy,
    output logic                   frame_loaded,
    output logic                   frame_short
);

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pins_async;
    logic [PIN_W-1:0] pins_sync;

    assign pins_async[PIN_CS]    = cs_n;
    assign pins_async[PIN_SCLK]  = sclk;
    assign pins_async[PIN_DIN]   = din;
    assign pins_async[PIN_LOAD]  = latch_load_strobe_n;
    assign pins_async[PIN_MODE]  = readback_or_chain_select;
    assign pins_async[PIN_RLVL]  = reset_level_select;
    assign pins_async[PIN_SLEEP] = sleep_pin;

    dsb_sync #(
        .W        (PIN_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .clk_en   (clk_en),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    logic cs_n_s;
    logic sclk_s;
    logic din_s;
    logic load_n_s;
    logic readback_s;
    logic mid_s;
    logic sleep_s;

    assign cs_n_s     = pins_sync[PIN_CS];
    assign sclk_s     = pins_sync[PIN_SCLK];
    assign din_s      = pins_sync[PIN_DIN];
    assign load_n_s   = pins_sync[PIN_LOAD];
    assign readback_s = pins_sync[PIN_MODE];
    assign mid_s      = pins_sync[PIN_RLVL];
    assign sleep_s    = pins_sync[PIN_SLEEP];

    // ------------------------------------------------------------------
    // edge detection on the synchronised serial pins
    // ------------------------------------------------------------------
    logic sclk_prev_r;
    logic sclk_prev_nxt;
    logic cs_prev_r;
    logic cs_prev_nxt;

    always_comb begin
        sclk_prev_nxt = sclk_prev_r;
        cs_prev_nxt   = cs_prev_r;
        if (!resetn) begin
            sclk_prev_nxt = 1'b0;
            cs_prev_nxt   = 1'b1;
        end else if (clk_en) begin
            sclk_prev_nxt = sclk_s;
            cs_prev_nxt   = cs_n_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        sclk_prev_r <= sclk_prev_nxt;
        cs_prev_r   <= cs_prev_nxt;
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    assign sclk_rise = sclk_s & ~sclk_prev_r;
    assign sclk_fall = ~sclk_s & sclk_prev_r;
    assign cs_fall   = ~cs_n_s & cs_prev_r;
    assign cs_rise   = cs_n_s & ~cs_prev_r;

    // ------------------------------------------------------------------
    // frame tracking and input shift register
    // ------------------------------------------------------------------
    dsb_state_t       state_r;
    dsb_state_t       state_nxt;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic              commit;
    logic              discard;

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        commit    = 1'b0;
        discard   = 1'b0;
        if (!resetn) begin
            state_nxt = DSB_IDLE;
            shift_nxt = WORD_ZERO;
            cnt_nxt   = CNT_ZERO;
        end else if (clk_en) begin
            case (state_r)
                DSB_IDLE: begin
                    if (cs_fall) begin // R8
                        state_nxt = DSB_FRAME;
                        cnt_nxt   = CNT_ZERO;
                    end
                end
                DSB_FRAME: begin
                    if (cs_rise) begin
                        state_nxt = DSB_CLOSE;
                    end else if (sclk_rise) begin
                        // msb arrives first and walks up the register
                        shift_nxt = {shift_r[MSB-1:0], din_s}; // R9 R24 R7
                        if (cnt_r != FRAME_BITS) begin
                            cnt_nxt = cnt_r + CNT_ONE; // R11
                        end
                    end
                end
                DSB_CLOSE: begin
                    state_nxt = DSB_IDLE;
                    if (cnt_r == FRAME_BITS) begin // R1 R12
                        commit = 1'b1;
                    end else begin
                        discard = 1'b1; // R10
                    end
                end
                default: begin
                    state_nxt = DSB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        state_r <= state_nxt;
        shift_r <= shift_nxt;
        cnt_r   <= cnt_nxt;
    end

    // ------------------------------------------------------------------
    // input register and output latch
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] inreg_r;
    logic [WORD_W-1:0] inreg_nxt;
    logic [WORD_W-1:0] latch_r;
    logic [WORD_W-1:0] latch_nxt;
    logic [WORD_W-1:0] reset_code;

    assign reset_code = mid_s ? CODE_MID : CODE_ZERO;

    always_comb begin
        inreg_nxt = inreg_r;
        latch_nxt = latch_r;
        if (!resetn) begin
            // strap is tracked for as long as reset is held
            inreg_nxt = reset_code; // R22
            latch_nxt = reset_code; // R22
        end else if (clk_en) begin
            if (commit) begin
                inreg_nxt = shift_r; // R12 R1
            end
            // the latch looks at the new input word, so a load in
            // transparent mode shows up in the same cycle as the commit
            if (!load_n_s) begin
                latch_nxt = inreg_nxt; // R4 R5 R6
            end else begin
                latch_nxt = latch_r; // R3
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        inreg_r <= inreg_nxt;
        latch_r <= latch_nxt;
    end

    // ------------------------------------------------------------------
    // serial output: readback of the input word or chain pass-through
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] out_sh_r;
    logic [WORD_W-1:0] out_sh_nxt;
    logic              sdo_r;
    logic              sdo_nxt;

    always_comb begin
        out_sh_nxt = out_sh_r;
        sdo_nxt    = sdo_r;
        if (!resetn) begin
            out_sh_nxt = WORD_ZERO;
            sdo_nxt    = 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                // first bit must be valid before the first rising edge
                out_sh_nxt = {inreg_r[MSB-1:0], 1'b0}; // R14
                sdo_nxt    = readback_s ? inreg_r[MSB] : shift_r[MSB];
            end else if (state_r == DSB_FRAME && sclk_fall) begin // R18
                if (readback_s) begin
                    sdo_nxt    = out_sh_r[MSB]; // R14 R15
                    out_sh_nxt = {out_sh_r[MSB-1:0], 1'b0}; // R15
                end else begin
                    sdo_nxt = shift_r[MSB]; // R17
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        out_sh_r <= out_sh_nxt;
        sdo_r    <= sdo_nxt;
    end

    // ------------------------------------------------------------------
    // status
    // ------------------------------------------------------------------
    logic loaded_r;
    logic loaded_nxt;
    logic short_r;
    logic short_nxt;
    logic busy_r;
    logic busy_nxt;
    logic sleep_r;
    logic sleep_nxt;

    always_comb begin
        loaded_nxt = loaded_r;
        short_nxt  = short_r;
        busy_nxt   = busy_r;
        sleep_nxt  = sleep_r;
        if (!resetn) begin
            loaded_nxt = 1'b0;
            short_nxt  = 1'b0;
            busy_nxt   = 1'b0;
            sleep_nxt  = 1'b0;
        end else if (clk_en) begin
            loaded_nxt = commit;
            short_nxt  = discard;
            busy_nxt   = (state_nxt != DSB_IDLE);
            // sleep only flags the analog side; serial path keeps running
            sleep_nxt  = sleep_s; // R23
        end
    end

    always_ff @(posedge ref_clk) begin
        loaded_r <= loaded_nxt;
        short_r  <= short_nxt;
        busy_r   <= busy_nxt;
        sleep_r  <= sleep_nxt;
    end

    assign sdo          = sdo_r;
    assign dac_code     = latch_r; // R2
    assign input_word   = inreg_r;
    assign powered_down = sleep_r;
    assign frame_busy   = busy_r;
    assign frame_loaded = loaded_r;
    assign frame_short  = short_r;

endmodule

// *** dsb_top_assertions.sv ***
// Purpose: port-level checks of the serial double-buffered code path
// Assumes: pins pass two sync flops, so pin effects lag a few cycles
// Notes:   strap is never moved on the same edge as a reset change
`timescale 1ns/1ps
module dsb_top_assertions
    import dsb_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              cs_n,
    input wire logic              latch_load_strobe_n,
    input wire logic              reset_level_select,
    input wire logic              sleep_pin,
    input wire logic              powered_down,
    input wire logic              frame_busy,
    input wire logic              frame_loaded,
    input wire logic              frame_short,
    input wire logic [WORD_W-1:0] dac_code,
    input wire logic [WORD_W-1:0] input_word
);
    default clocking cb @(posedge ref_clk);
    endclocking

    // counts edges in reset with the strap unchanged; the strap needs
    // three edges through the synchroniser before the code shows it
    logic       sel_prev_r = 1'b0;
    logic [2:0] settle_r   = 3'h0;

    always_ff @(posedge ref_clk) begin
        sel_prev_r <= reset_level_select;
        if (resetn || reset_level_select != sel_prev_r) begin
            settle_r <= 3'h0;
        end else if (settle_r != 3'h4) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    sequence strobe_fall;
        $fell(latch_load_strobe_n) ##1 !latch_load_strobe_n [*3];
    endsequence

    sequence cs_open;
        $fell(cs_n) ##1 !cs_n [*3];
    endsequence

    chk_reset_code: assert property (!resetn && settle_r == 3'h4 |->
        input_word == {reset_level_select, 15'h0000} &&
        dac_code == {reset_level_select, 15'h0000})
        else $error("reset code wrong");
    chk_latch_hold: assert property (disable iff (!resetn)
        latch_load_strobe_n [*5] |-> $stable(dac_code))
        else $error("latch moved while strobe high");
    chk_latch_follow: assert property (disable iff (!resetn)
        !latch_load_strobe_n [*5] |-> dac_code == input_word)
        else $error("latch not transparent");
    chk_strobe_load: assert property (disable iff (!resetn)
        strobe_fall |-> dac_code == input_word)
        else $error("strobe fall did not load latch");
    chk_load_frame: assert property (disable iff (!resetn)
        frame_loaded |-> $past(frame_busy) && !frame_short)
        else $error("load without a frame");
    chk_word_stable: assert property (disable iff (!resetn)
        !frame_loaded |-> $stable(input_word))
        else $error("input word changed without load");
    chk_busy_open: assert property (disable iff (!resetn)
        cs_open |-> frame_busy)
        else $error("frame not opened");
    chk_commit_time: assert property (disable iff (!resetn)
        $rose(cs_n) && frame_busy |-> ##[2:5] (frame_loaded || frame_short))
        else $error("frame not closed in time");
    chk_idle_busy: assert property (disable iff (!resetn)
        cs_n [*6] |-> !frame_busy)
        else $error("busy while deselected");
    chk_sleep_mirror: assert property (disable iff (!resetn)
        sleep_pin [*4] |-> powered_down)
        else $error("sleep not reported");
endmodule

bind dsb_top dsb_top_assertions u_chk (.ref_clk, .resetn, .cs_n,
    .latch_load_strobe_n, .reset_level_select, .sleep_pin, .powered_down,
    .frame_busy, .frame_loaded, .frame_short, .dac_code, .input_word);

// *** dsb_master_model.sv ***
// Purpose: serial master driving the write port of the block
// Assumes: sclk stands low between frames, bits change while it is low
// Notes:   din shows the inverse of its last bit once released
`timescale 1ns/1ps
module dsb_master_model (
    input  wire logic        ref_clk,
    input  wire logic        sdo,
    output logic             cs_n,
    output logic             sclk,
    output logic             din,
    output logic [31:0]      rd_bits
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        rd_bits = 32'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // low n bits of w; a chain of N parts takes n = 16*N
    task automatic send(input logic [31:0] w, input int n);
        int i;
        cs_n = 1'b0;
        tick(4);
        for (i = n - 1; i >= 0; i--) begin
            din = w[i];
            tick(4);
            rd_bits = {rd_bits[30:0], sdo};
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        din = ~din;
        tick(8);
    endtask
endmodule

// *** dsb_top_bench.sv ***
// Purpose: self-checking bench of the serial double-buffered code path
// Assumes: ref_clk 40 MHz, serial clock 200 ns from the master model
// Notes:   waits after each frame cover the synchroniser latency
`timescale 1ns/1ps
module dsb_top_bench;
    import dsb_pkg::*;
    logic              ref_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              latch_load_strobe_n = 1'b0;
    logic              readback_or_chain_select = 1'b1;
    logic              reset_level_select = 1'b1;
    logic              sleep_pin = 1'b0;
    logic              cs_n, sclk, din, sdo, powered_down;
    logic              frame_busy, frame_loaded, frame_short;
    logic [WORD_W-1:0] dac_code, input_word;
    logic [31:0]       rd;
    int                miscompares = 0;
    int                n_compared = 0;

    always #12.5 ref_clk = ~ref_clk;

    dsb_top DUT (.ref_clk, .resetn, .clk_en(1'b1), .cs_n, .sclk, .din,
        .latch_load_strobe_n, .readback_or_chain_select,
        .reset_level_select, .sleep_pin, .sdo, .dac_code, .input_word,
        .powered_down, .frame_busy, .frame_loaded, .frame_short);
    dsb_master_model m (.ref_clk, .sdo, .cs_n, .sclk, .din, .rd_bits(rd));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // strap moves a few cycles ahead of reset so it is synced in time
    task automatic do_reset(input logic lvl);
        reset_level_select = lvl;
        wt(4);
        resetn = 1'b0;
        wt(10);
        chk(input_word, {lvl, 15'h0000});
        chk(dac_code, {lvl, 15'h0000});
        resetn = 1'b1;
        wt(4);
    endtask

    initial begin
        do_reset(1'b1);
        m.send(32'h0000A5C3, 16);
        wt(6);
        chk(input_word, 16'hA5C3);
        chk(dac_code, 16'hA5C3);
        chk(rd[15:0], 16'h8000);
        // readback of this short frame is partial and not looked at
        m.send(32'h00007777, 15);
        wt(6);
        chk(input_word, 16'hA5C3);
        chk(dac_code, 16'hA5C3);
        latch_load_strobe_n = 1'b1;
        m.send(32'h00123456, 24);
        wt(6);
        chk(input_word, 16'h3456);
        chk(dac_code, 16'hA5C3);
        chk(rd[23:8], 16'hA5C3);
        chk({8'h00, rd[7:0]}, 16'h0000);
        latch_load_strobe_n = 1'b0;
        wt(4);
        chk(dac_code, 16'h3456);
        readback_or_chain_select = 1'b0;
        sleep_pin = 1'b1;
        wt(4);
        m.send(32'hBEEF1234, 32);
        wt(6);
        chk(input_word, 16'h1234);
        chk(dac_code, 16'h1234);
        chk(rd[15:0], 16'hBEEF);
        chk({15'h0000, powered_down}, 16'h0001);
        sleep_pin = 1'b0;
        do_reset(1'b0);
        tally_and_finish;
    end

    initial begin
        wt(5000);
        miscompares++;
        tally_and_finish;
    end
endmodule
